/* rtl/lcv_defs.svh */
`ifndef LCV_DEFS_SVH
`define LCV_DEFS_SVH
// Operation
// - smoothing duration set in 10 ms steps
// - average count is duration over cycle time
// - smoothing duration clamped near 100 ms
// - default smoothing zero, raw values pass
// - real length is attenuation minus correction
// - length correction limited to 0..20 dm
// - direction off keeps wrong-way flag zero
// - first-then-second normal; reverse flags wrong-way
// - second-then-first normal; forward flags wrong-way
// - slow reverse vehicles give no wrong-way
// - unique bus address, parameter or switch
// - sensitivity automatic, measurement time preset
// - hold timer starts at each detection
// - hold expiry while occupied resets channel
// - full sensitivity 4 s after leaving
// - hold time infinite by default, finite optional
// - count hold-expiry realignments as diagnostic
// - realign only on measurement-relevant change

// register byte offsets
`define LCV_OFF_CTRL    8'h00
`define LCV_OFF_LENCORR 8'h04
`define LCV_OFF_MINSPD  8'h08
`define LCV_OFF_HOLD    8'h0C
`define LCV_OFF_ADDR    8'h10
`define LCV_OFF_STAT    8'h14
`define LCV_OFF_MASK    8'h18
`define LCV_OFF_RESULT  8'h1C
`define LCV_OFF_MEAN    8'h20
`define LCV_OFF_DIAG    8'h24
`define LCV_OFF_MTIME   8'h28

// field limits and reset values
`define LCV_SMOOTH_STEP_MS 8'h0A
`define LCV_SMOOTH_MAX     7'h0A
`define LCV_LENCORR_MAX    5'h14
`define LCV_LENCORR_RST    5'h00
`define LCV_MINSPD_RST     8'h14
`define LCV_HOLD_RST       6'h00
`define LCV_ADDR_RST       8'h01
`define LCV_MTIME_PRESET   8'h04

// status bits
`define LCV_ST_RESULT 0
`define LCV_ST_WRONG  1
`define LCV_ST_HOLD   2

// timing
`define LCV_CLK_NS     25
`define LCV_MS_NS      1000000
`define LCV_RECOV_MS   4000
`define LCV_MS_PER_S   1000
`endif

/* rtl/lcv_pkg.sv */
package lcv_pkg;
  // direction evaluation modes
  typedef enum logic [1:0] {
    LCV_DIR_OFF = 2'h0,
    LCV_DIR_FWD = 2'h1,
    LCV_DIR_REV = 2'h2
  } lcv_dir_t;

  // hold supervision states, one-hot
  typedef enum logic [3:0] {
    LCV_H_IDLE   = 4'h1,
    LCV_H_OCC    = 4'h2,
    LCV_H_IGNORE = 4'h4,
    LCV_H_RECOV  = 4'h8
  } lcv_hold_t;

  // one finished passage from the double loop
  typedef struct packed {
    logic       order_21;
    logic [7:0] speed_kmh;
    logic [7:0] atten_dm;
  } lcv_pass_t;

  // evaluated vehicle result
  typedef struct packed {
    logic       wrong_way;
    logic       rev_code;
    logic       order_21;
    logic [7:0] real_dm;
  } lcv_result_t;
endpackage

/* rtl/lcv_chan_eval.sv */
// Implementation choices: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "lcv_defs.svh"
module lcv_chan_eval #(
  parameter int P_MS_CYC = (`LCV_MS_NS + `LCV_CLK_NS - 1) / `LCV_CLK_NS
) (
  input  wire logic                i_sys_clk,    // 40 MHz
  input  wire logic                i_rst,        // sync, high
  input  wire logic                i_ce,         // freezes state when low
  // apb slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  // measurement stream
  input  wire logic                i_meas_valid,
  input  wire logic [15:0]         i_meas_value,
  input  wire logic [7:0]          i_cycle_ms,   // current cycle time
  output logic                     o_mean_valid,
  output logic      [15:0]         o_mean_value,
  // loop occupancy and passages
  input  wire logic                i_occupied,
  input  wire logic                i_pass_valid,
  input  wire lcv_pkg::lcv_pass_t  i_pass,
  output logic                     o_result_valid,
  output lcv_pkg::lcv_result_t     o_result,
  // address switch pins
  input  wire logic [2:0]          i_hw_addr,
  output logic      [7:0]          o_bus_addr,
  // channel supervision
  output logic                     o_realign,
  output logic                     o_recovering,
  output logic                     o_irq
);

  // cycles per millisecond, at least one
  localparam int MS_CYC = (P_MS_CYC < 1) ? 1 : P_MS_CYC;

  // restoring divider shared by averaging count and mean
  function automatic logic [23:0] div24(input logic [23:0] a, input logic [23:0] b);
    logic [24:0] r;
    logic [23:0] q;
    r = '0;
    q = '0;
    if (b != 24'h0) begin
      for (int i = 23; i >= 0; i--) begin
        r = {r[23:0], a[i]};
        if (r >= {1'b0, b}) begin
          r = r - {1'b0, b};
          q[i] = 1'b1;
        end
      end
    end
    return q;
  endfunction

  // configuration registers
  logic [6:0]  smooth_q, smooth_d;     // units of 10 ms
  lcv_pkg::lcv_dir_t dir_q, dir_d;     // direction mode
  logic [4:0]  lcorr_q, lcorr_d;       // length correction, dm
  logic [7:0]  minspd_q, minspd_d;     // reverse speed floor
  logic [5:0]  hold_q, hold_d;         // seconds, 0 infinite
  logic [7:0]  addr_q, addr_d;         // bus address parameter
  logic        usehw_q, usehw_d;       // take switch address
  logic [2:0]  stat_q, stat_d;         // sticky events
  logic [2:0]  mask_q, mask_d;         // interrupt enables
  logic [15:0] diag_q, diag_d;         // hold realign count
  logic        cfg_chg;                // relevant setting changed

  // synchronised switch pins
  logic [2:0]  hw_s1_q, hw_s2_q;

  // averaging state
  logic [23:0] acc_q, acc_d;           // running sum
  logic [6:0]  cnt_q, cnt_d;           // samples taken
  logic [23:0] navg;                   // values to average
  logic [23:0] dur_ms;                 // smoothing in ms
  logic [23:0] sum_now;                // sum with new sample
  logic        mv_d;
  logic [15:0] mean_d;

  // result path
  logic        rv_d;
  lcv_pkg::lcv_result_t res_d;
  logic        ww_raw;                 // direction says reverse

  // hold supervision
  lcv_pkg::lcv_hold_t hst_q, hst_d;
  logic [15:0] ms_pre_q, ms_pre_d;     // cycle prescaler
  logic [15:0] htmr_q, htmr_d;         // ms timer
  logic        tick;                   // one ms elapsed
  logic        occ_q;                  // occupancy last cycle
  logic        realign_d, hold_exp;

  // apb decode
  logic        apb_wr, apb_rd, hit;
  logic [31:0] rdata_d;

  assign apb_wr  = psel & penable & pwrite;
  assign apb_rd  = psel & ~penable & ~pwrite; // read setup phase
  assign pready  = 1'b1;               // zero wait state
  assign pslverr = psel & penable & ~hit;
  assign o_irq   = |(stat_q & mask_q);

  // address decode and read mux
  always_comb begin
    hit     = 1'b1;
    rdata_d = 32'h0;
    case (paddr)
      `LCV_OFF_CTRL:    rdata_d = {23'h0, dir_q, smooth_q};
      `LCV_OFF_LENCORR: rdata_d = {27'h0, lcorr_q};
      `LCV_OFF_MINSPD:  rdata_d = {24'h0, minspd_q};
      `LCV_OFF_HOLD:    rdata_d = {26'h0, hold_q};
      `LCV_OFF_ADDR:    rdata_d = {23'h0, usehw_q, addr_q};
      `LCV_OFF_STAT:    rdata_d = {29'h0, stat_q};
      `LCV_OFF_MASK:    rdata_d = {29'h0, mask_q};
      `LCV_OFF_RESULT:  rdata_d = {21'h0, o_result};
      `LCV_OFF_MEAN:    rdata_d = {16'h0, o_mean_value};
      `LCV_OFF_DIAG:    rdata_d = {16'h0, diag_q};
      `LCV_OFF_MTIME:   rdata_d = {24'h0, `LCV_MTIME_PRESET};
      default:          hit = 1'b0;
    endcase
  end

  // read data loads at the setup edge so it stands through the access phase
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      prdata <= 32'h0;
    end else if (i_ce && apb_rd) begin
      prdata <= rdata_d;
    end
  end

  // configuration and status next values
  always_comb begin
    smooth_d = smooth_q;
    dir_d    = dir_q;
    lcorr_d  = lcorr_q;
    minspd_d = minspd_q;
    hold_d   = hold_q;
    addr_d   = addr_q;
    usehw_d  = usehw_q;
    mask_d   = mask_q;
    stat_d   = stat_q;
    diag_d   = diag_q;
    cfg_chg  = 1'b0;
    if (apb_wr) begin
      case (paddr)
        `LCV_OFF_CTRL: begin
          // duration in 10 ms steps, clamped
          if (pwdata[6:0] > `LCV_SMOOTH_MAX) begin
            smooth_d = `LCV_SMOOTH_MAX;
          end else begin
            smooth_d = pwdata[6:0];
          end
          dir_d = lcv_pkg::lcv_dir_t'(pwdata[8:7]);
          cfg_chg = (smooth_d != smooth_q) || (dir_d != dir_q);
        end
        `LCV_OFF_LENCORR: begin
          // correction clamped, never causes realign
          if (pwdata[7:0] > {3'h0, `LCV_LENCORR_MAX}) begin
            lcorr_d = `LCV_LENCORR_MAX;
          end else begin
            lcorr_d = pwdata[4:0];
          end
        end
        `LCV_OFF_MINSPD: minspd_d = pwdata[7:0];
        `LCV_OFF_HOLD: begin
          hold_d  = pwdata[5:0];
          cfg_chg = (hold_d != hold_q);
        end
        `LCV_OFF_ADDR: begin
          addr_d  = pwdata[7:0];
          usehw_d = pwdata[8];
        end
        `LCV_OFF_MASK: mask_d = pwdata[2:0];
        `LCV_OFF_STAT: stat_d = stat_q & ~pwdata[2:0];
        default: begin
          // read-only or unmapped: nothing stored
        end
      endcase
    end
    // events set after the clear so a set wins
    if (rv_d) begin
      stat_d[`LCV_ST_RESULT] = 1'b1;
    end
    if (rv_d && res_d.wrong_way) begin
      stat_d[`LCV_ST_WRONG] = 1'b1;
    end
    if (hold_exp) begin
      stat_d[`LCV_ST_HOLD] = 1'b1;
      if (diag_q != 16'hFFFF) begin
        diag_d = diag_q + 16'h1;
      end
    end
  end

  // configuration and status registers
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      smooth_q <= 7'h0;
      dir_q    <= lcv_pkg::LCV_DIR_OFF;
      lcorr_q  <= `LCV_LENCORR_RST;
      minspd_q <= `LCV_MINSPD_RST;
      hold_q   <= `LCV_HOLD_RST;
      addr_q   <= `LCV_ADDR_RST;
      usehw_q  <= 1'b1;
      mask_q   <= 3'h0;
      stat_q   <= 3'h0;
      diag_q   <= 16'h0;
    end else if (i_ce) begin
      smooth_q <= smooth_d;
      dir_q    <= dir_d;
      lcorr_q  <= lcorr_d;
      minspd_q <= minspd_d;
      hold_q   <= hold_d;
      addr_q   <= addr_d;
      usehw_q  <= usehw_d;
      mask_q   <= mask_d;
      stat_q   <= stat_d;
      diag_q   <= diag_d;
    end
  end

  // switch pins cross in through two flops
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      hw_s1_q <= 3'h0;
      hw_s2_q <= 3'h0;
    end else if (i_ce) begin
      hw_s1_q <= i_hw_addr;
      hw_s2_q <= hw_s1_q;
    end
  end

  // bus address: switch when enabled and nonzero
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_bus_addr <= `LCV_ADDR_RST;
    end else if (i_ce) begin
      o_bus_addr <= (usehw_q && hw_s2_q != 3'h0) ? {5'h0, hw_s2_q} : addr_q;
    end
  end

  // averaging count and next mean
  always_comb begin
    dur_ms  = 24'(smooth_q) * 24'(`LCV_SMOOTH_STEP_MS);
    navg    = div24(dur_ms, {16'h0, i_cycle_ms});
    sum_now = acc_q + {8'h0, i_meas_value};
    acc_d   = acc_q;
    cnt_d   = cnt_q;
    mv_d    = 1'b0;
    mean_d  = o_mean_value;
    if (i_meas_valid) begin
      if (navg <= 24'h1) begin
        // no averaging: raw sample forwarded
        mv_d   = 1'b1;
        mean_d = i_meas_value;
        acc_d  = 24'h0;
        cnt_d  = 7'h0;
      end else if ({17'h0, cnt_q} + 24'h1 >= navg) begin
        // block complete: emit mean, restart
        mv_d   = 1'b1;
        mean_d = 16'(div24(sum_now, navg));
        acc_d  = 24'h0;
        cnt_d  = 7'h0;
      end else begin
        acc_d = sum_now;
        cnt_d = cnt_q + 7'h1;
      end
    end
    if (realign_d) begin
      // realignment discards a partial block
      acc_d = 24'h0;
      cnt_d = 7'h0;
    end
  end

  // averaging registers
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      acc_q        <= 24'h0;
      cnt_q        <= 7'h0;
      o_mean_valid <= 1'b0;
      o_mean_value <= 16'h0;
    end else if (i_ce) begin
      acc_q        <= acc_d;
      cnt_q        <= cnt_d;
      o_mean_valid <= mv_d;
      o_mean_value <= mean_d;
    end
  end

  // passage evaluation: length and direction
  always_comb begin
    case (dir_q)
      lcv_pkg::LCV_DIR_FWD: ww_raw = i_pass.order_21;
      lcv_pkg::LCV_DIR_REV: ww_raw = ~i_pass.order_21;
      default:              ww_raw = 1'b0;
    endcase
    res_d.order_21  = i_pass.order_21;
    res_d.rev_code  = ww_raw;
    res_d.wrong_way = ww_raw && (i_pass.speed_kmh >= minspd_q);
    if (i_pass.atten_dm > {3'h0, lcorr_q}) begin
      res_d.real_dm = i_pass.atten_dm - {3'h0, lcorr_q};
    end else begin
      res_d.real_dm = 8'h0;
    end
    // ignored vehicles give no result
    rv_d = i_pass_valid && (hst_q == lcv_pkg::LCV_H_IDLE || hst_q == lcv_pkg::LCV_H_OCC);
  end

  // result registers
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_result_valid <= 1'b0;
      o_result       <= '0;
    end else if (i_ce) begin
      o_result_valid <= rv_d;
      if (rv_d) begin
        o_result <= res_d;
      end
    end
  end

  // hold supervision next state
  always_comb begin
    hst_d     = hst_q;
    htmr_d    = htmr_q;
    hold_exp  = 1'b0;
    realign_d = cfg_chg;
    tick      = (ms_pre_q == 16'(MS_CYC - 1));
    ms_pre_d  = tick ? 16'h0 : ms_pre_q + 16'h1;
    case (hst_q)
      lcv_pkg::LCV_H_IDLE: begin
        if (i_occupied && !occ_q) begin
          hst_d  = lcv_pkg::LCV_H_OCC;
          htmr_d = 16'h0;
          ms_pre_d = 16'h0;
        end
      end
      lcv_pkg::LCV_H_OCC: begin
        if (!i_occupied) begin
          hst_d = lcv_pkg::LCV_H_IDLE;
        end else if (hold_q != 6'h0 && tick) begin
          if (htmr_q + 16'h1 >= 16'(hold_q) * 16'(`LCV_MS_PER_S)) begin
            hst_d     = lcv_pkg::LCV_H_IGNORE;
            hold_exp  = 1'b1;
            realign_d = 1'b1;
          end else begin
            htmr_d = htmr_q + 16'h1;
          end
        end
      end
      lcv_pkg::LCV_H_IGNORE: begin
        // ignored vehicle still present
        if (!i_occupied) begin
          hst_d    = lcv_pkg::LCV_H_RECOV;
          htmr_d   = 16'h0;
          ms_pre_d = 16'h0;
        end
      end
      lcv_pkg::LCV_H_RECOV: begin
        if (i_occupied) begin
          hst_d = lcv_pkg::LCV_H_IGNORE;
        end else if (tick) begin
          if (htmr_q + 16'h1 >= 16'(`LCV_RECOV_MS)) begin
            hst_d = lcv_pkg::LCV_H_IDLE;
          end else begin
            htmr_d = htmr_q + 16'h1;
          end
        end
      end
      default: hst_d = lcv_pkg::LCV_H_IDLE;
    endcase
  end

  // hold supervision registers
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      hst_q        <= lcv_pkg::LCV_H_IDLE;
      htmr_q       <= 16'h0;
      ms_pre_q     <= 16'h0;
      occ_q        <= 1'b0;
      o_realign    <= 1'b0;
      o_recovering <= 1'b0;
    end else if (i_ce) begin
      hst_q        <= hst_d;
      htmr_q       <= htmr_d;
      ms_pre_q     <= ms_pre_d;
      occ_q        <= i_occupied;
      o_realign    <= realign_d;
      o_recovering <= (hst_d == lcv_pkg::LCV_H_IGNORE) || (hst_d == lcv_pkg::LCV_H_RECOV);
    end
  end

endmodule
`default_nettype wire

/* testbench/lcv_chan_eval_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module lcv_chan_eval_assertions (
  input wire logic                 i_sys_clk,
  input wire logic                 i_rst,
  input wire logic                 i_ce,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [7:0]           paddr,
  input wire logic [31:0]          pwdata,
  input wire logic                 pready,
  input wire logic                 i_meas_valid,
  input wire logic [15:0]          i_meas_value,
  input wire logic [7:0]           i_cycle_ms,
  input wire logic                 o_mean_valid,
  input wire logic [15:0]          o_mean_value,
  input wire logic                 i_pass_valid,
  input wire lcv_pkg::lcv_pass_t   i_pass,
  input wire logic                 o_result_valid,
  input wire lcv_pkg::lcv_result_t o_result,
  input wire logic [7:0]           o_bus_addr,
  input wire logic                 o_realign,
  input wire logic                 o_recovering
);
  logic [6:0] smooth_q, smooth_d;  // mirrored smoothing setting
  logic [1:0] dir_q, dir_d;        // mirrored direction mode
  logic [4:0] corr_q, corr_d;      // mirrored length correction
  logic [7:0] spd_q, spd_d;        // mirrored minimum speed
  logic       wr, raw, rev, pass_ok;
  logic [7:0] len;                 // expected real length
  // mirror the settings from apb writes, clamping as the block does
  always_comb begin
    wr = psel && penable && pwrite && pready && i_ce;
    smooth_d = smooth_q;
    dir_d = dir_q;
    corr_d = corr_q;
    spd_d = spd_q;
    if (wr && paddr == 8'h00) begin
      smooth_d = (pwdata[6:0] > 7'h0A) ? 7'h0A : pwdata[6:0];
      dir_d = pwdata[8:7];
    end
    if (wr && paddr == 8'h04) corr_d = (pwdata[7:0] > 8'h14) ? 5'h14 : pwdata[4:0];
    if (wr && paddr == 8'h08) spd_d = pwdata[7:0];
    raw = (i_cycle_ms == 8'h00) || (10'(smooth_q) * 10'h00A < 10'({i_cycle_ms, 1'b0}));
    rev = (dir_q == 2'h1 && i_pass.order_21) || (dir_q == 2'h2 && !i_pass.order_21);
    len = (i_pass.atten_dm > 8'(corr_q)) ? i_pass.atten_dm - 8'(corr_q) : 8'h00;
    pass_ok = i_pass_valid && !o_recovering && i_ce;
  end
  // register the mirror, reset to the documented defaults
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      smooth_q <= 7'h00;
      dir_q <= 2'h0;
      corr_q <= 5'h00;
      spd_q <= 8'h14;
    end else begin
      smooth_q <= smooth_d;
      dir_q <= dir_d;
      corr_q <= corr_d;
      spd_q <= spd_d;
    end
  end
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  AST_RAW_PASS: assert property (i_meas_valid && i_ce && raw |=>
    o_mean_valid && o_mean_value == $past(i_meas_value)) else $error("raw value not forwarded");
  AST_MEAN_CAUSE: assert property (o_mean_valid |-> $past(i_meas_valid))
    else $error("mean without a measurement");
  AST_REAL_LEN: assert property (pass_ok |=> o_result.real_dm == $past(len))
    else $error("real length wrong");
  AST_DIR_OFF: assert property (pass_ok && dir_q != 2'h1 && dir_q != 2'h2 |=>
    !o_result.wrong_way && !o_result.rev_code) else $error("flag set with direction off");
  AST_REV_CODE: assert property (pass_ok |=> o_result_valid && o_result.rev_code == $past(rev)
    && o_result.order_21 == $past(i_pass.order_21)) else $error("readout code wrong");
  AST_WRONG_FLAG: assert property (pass_ok |=>
    o_result.wrong_way == $past(rev && i_pass.speed_kmh >= spd_q)) else $error("wrong-way flag wrong");
  AST_EXPIRY_REALIGN: assert property ($rose(o_recovering) |-> o_realign || $past(o_realign))
    else $error("expiry without realign");
  AST_IGNORE_PASS: assert property (o_recovering && i_pass_valid |=> !o_result_valid)
    else $error("ignored vehicle reported");
  AST_NO_REALIGN: assert property (wr && (paddr == 8'h04 || paddr == 8'h08) |=> !o_realign [*2])
    else $error("realign on non-measurement setting");
  AST_ADDR_RST: assert property ($fell(i_rst) |-> o_bus_addr == 8'h01)
    else $error("bus address reset value wrong");
  cover property (o_recovering);
  cover property (o_result_valid && o_result.wrong_way);
  cover property (o_mean_valid && !raw);
endmodule
bind lcv_chan_eval lcv_chan_eval_assertions u_chk (.i_sys_clk, .i_rst, .i_ce, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pready, .i_meas_valid, .i_meas_value, .i_cycle_ms, .o_mean_valid, .o_mean_value,
  .i_pass_valid, .i_pass, .o_result_valid, .o_result, .o_bus_addr, .o_realign, .o_recovering);
`default_nettype wire

/* testbench/lcv_loop_model.sv */
`timescale 1ns/1ps
`default_nettype none
module lcv_loop_model (
  input wire logic                i_sys_clk,
  input wire logic                i_go,    // request one passage
  input wire lcv_pkg::lcv_pass_t  i_req,   // passage contents
  output logic                    o_pass_valid,
  output lcv_pkg::lcv_pass_t      o_pass
);
  initial begin
    o_pass_valid = 1'b0;
    o_pass = '0;
  end
  // one-cycle passage; fields scrambled while idle so stale data is never reused
  always @(posedge i_sys_clk) begin
    o_pass_valid <= i_go;
    o_pass <= i_go ? i_req : ~o_pass;
  end
endmodule
`default_nettype wire

/* testbench/loop_channel_vehicle_eval_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module loop_channel_vehicle_eval_tb;
  logic                 clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic                 mv = 1'b0, occ = 1'b0, go = 1'b0, ce = 1'b1, err, pready, pslverr;
  logic                 mean_v, pv, res_v, realign, recov, irq;
  logic [7:0]           paddr = 8'h00, cyc = 8'h05, bus_addr;
  logic [31:0]          pwdata = 32'h0, prdata, rd, seed = 32'h0F226F5B;
  logic [15:0]          mval = 16'h0, mean;
  logic [2:0]           hw = 3'h0;
  lcv_pkg::lcv_pass_t   req = '0, pass;
  lcv_pkg::lcv_result_t res;
  int                   num_errors = 0, check_count = 0, n;
  logic [15:0]          mq[$];  // expected means
  logic [10:0]          rq[$];  // expected results
  always #12.5 clk = ~clk;
  lcv_chan_eval #(.P_MS_CYC(4)) u_dut (.i_sys_clk(clk), .i_rst(rst), .i_ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .i_meas_valid(mv), .i_meas_value(mval), .i_cycle_ms(cyc), .o_mean_valid(mean_v),
    .o_mean_value(mean), .i_occupied(occ), .i_pass_valid(pv), .i_pass(pass), .o_result_valid(res_v),
    .o_result(res), .i_hw_addr(hw), .o_bus_addr(bus_addr), .o_realign(realign), .o_recovering(recov),
    .o_irq(irq));
  lcv_loop_model u_loop (.i_sys_clk(clk), .i_go(go), .i_req(req), .o_pass_valid(pv), .o_pass(pass));
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: saw %h want %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // apb transfer; write lands and read data is taken at the edge where pready is high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    err = pslverr;
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(rd, e);
  endtask
  // send nv random measurements, noting the raw value or the block mean
  task automatic block(input int nv);
    logic [19:0] sum;
    sum = '0;
    for (int i = 0; i < nv; i++) begin
      seed = lfsr(seed);
      sum += 20'(seed[15:0]);
      if (nv == 1 || i == nv - 1) mq.push_back(nv == 1 ? seed[15:0] : 16'(sum / nv));
      mv <= 1'b1;
      mval <= seed[15:0];
      @(posedge clk);
      mv <= 1'b0;
      @(posedge clk);
    end
  endtask
  // one passage through the loop model; keep low means it must be ignored
  task automatic pass_chk(input logic o, input logic [7:0] spd, input logic [7:0] att,
                          input logic [1:0] dir, input logic [4:0] corr, input logic keep);
    logic rev;
    rev = (dir == 2'h1 && o) || (dir == 2'h2 && !o);
    if (keep) rq.push_back({rev && spd >= 8'h14, rev, o, att > 8'(corr) ? att - 8'(corr) : 8'h00});
    req <= '{o, spd, att};
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  // compare each output pulse with the oldest note
  always @(posedge clk) begin
    if (mean_v === 1'b1) check(32'(mean), mq.size() ? 32'(mq.pop_front()) : 32'h1_0000);
    if (res_v === 1'b1) check(32'(res), rq.size() ? 32'(rq.pop_front()) : 32'h800);
  end
  initial begin
    repeat (50000) @(posedge clk);
    num_errors++;
    report_and_stop();
  end
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rchk(8'h00, 32'h0);
    rchk(8'h04, 32'h0);
    rchk(8'h08, 32'h14);
    rchk(8'h0C, 32'h0);
    rchk(8'h10, 32'h101);
    apb(1'b1, 8'h28, 32'hFF);
    rchk(8'h28, 32'h4);
    apb(1'b0, 8'h40, 32'h0);
    check(err, 32'h1);
    repeat (3) block(1);
    apb(1'b1, 8'h00, 32'h2);
    block(4);
    apb(1'b1, 8'h00, 32'h0F);
    rchk(8'h00, 32'h0A);
    cyc <= 8'h19;
    block(4);
    apb(1'b1, 8'h00, 32'h1);
    cyc <= 8'h0A;
    block(1);
    apb(1'b1, 8'h04, 32'h19);
    rchk(8'h04, 32'h14);
    apb(1'b1, 8'h08, 32'h14);
    pass_chk(1'b1, 8'h30, 8'h32, 2'h0, 5'h14, 1'b1);
    pass_chk(1'b0, 8'h30, 8'h0A, 2'h0, 5'h14, 1'b1);
    for (int d = 0; d < 3; d++) begin
      apb(1'b1, 8'h00, 32'(d) << 7);
      for (int o = 0; o < 4; o++) begin
        seed = lfsr(seed);
        pass_chk(o[0], o[1] ? 8'h13 : 8'h14, seed[7:0], d[1:0], 5'h14, 1'b1);
      end
    end
    rchk(8'h14, 32'h3);
    apb(1'b1, 8'h18, 32'h2);
    check(irq, 32'h1);
    apb(1'b1, 8'h14, 32'h2);
    rchk(8'h14, 32'h1);
    check(irq, 32'h0);
    hw <= 3'h5;
    apb(1'b1, 8'h10, 32'h2A);
    repeat (3) @(posedge clk);
    check(bus_addr, 32'h2A);
    apb(1'b1, 8'h10, 32'h12A);
    repeat (3) @(posedge clk);
    check(bus_addr, 32'h5);
    occ <= 1'b1;
    repeat (5000) @(posedge clk);
    check(recov, 32'h0);
    occ <= 1'b0;
    apb(1'b1, 8'h0C, 32'h1);
    occ <= 1'b1;
    n = 0;
    while (recov !== 1'b1 && n < 6000) begin @(posedge clk); n++; end
    check(32'(n > 3980 && n < 4030), 32'h1);
    pass_chk(1'b0, 8'h30, 8'h30, 2'h2, 5'h14, 1'b0);
    rchk(8'h24, 32'h1);
    rchk(8'h14, 32'h5);
    occ <= 1'b0;
    repeat (8000) @(posedge clk);
    check(recov, 32'h1);
    occ <= 1'b1;
    repeat (10) @(posedge clk);
    occ <= 1'b0;
    n = 0;
    while (recov !== 1'b0 && n < 20000) begin @(posedge clk); n++; end
    check(32'(n > 15980 && n < 16030), 32'h1);
    ce <= 1'b0;
    mv <= 1'b1;
    @(posedge clk);
    mv <= 1'b0;
    repeat (2) @(posedge clk);
    check(32'(mean_v), 32'h0);
    ce <= 1'b1;
    repeat (5) @(posedge clk);
    check(32'(mq.size() + rq.size()), 32'h0);
    report_and_stop();
  end
endmodule
`default_nettype wire
